// ### omed_detector.v
// Orientation debounce and freefall/motion event detection with register port
//
// Functional notes
// - Config bit: 0 decrement, 1 clear on loss
// - Orientation detection runs only while enabled
// - Eight-bit orientation debounce count, resets zero
// - Latency is count times selected time step
// - Wake/sleep change resets orientation debounce counter
// - Time step follows rate, capped per mode
// - Back/front trip code fixed at 01
// - Tilt lockout code fixed at 100
// - Orientation trip code fixed at 1_0000
// - Hysteresis code fixed at 100
// - Combine select: AND freefall, OR motion
// - Only enabled axes count; none disables
// - Event flag sets only after debounce completes
// - Non-latched, mode 0: flag holds while decrementing
// - Non-latched, mode 1: clears at once, refull
// - Non-latched: source read has no effect
// - Axis flags follow raw high-g status
// - Latched: read clears flag and counter
// - Latched: axis flags frozen while flag set
// - Latched motion: read clears whole source
// - Change flag on first detection, changes; read clears
// - Freefall at or below threshold, motion above
`timescale 1ns/10ps
`include "omed_consts.vh"
module omed_detector #(
	parameter DW = 8
) (
	// Clock and reset
	input wire clk_sys_in,
	input wire rst_b_in,
	// Register port
	input wire [7:0] reg_addr_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_wdata_in,
	output reg [7:0] reg_rdata_out,
	// Sample timing and power state
	input wire sample_tick_in,
	input wire wake_sleep_change_in,
	input wire standby_to_active_in,
	input wire [2:0] odr_sel_in,
	input wire [1:0] os_mode_in,
	// Orientation candidate {lockout, landscape/portrait[1:0], back}
	input wire [3:0] orient_cand_in,
	// Signed axis samples
	input wire [DW-1:0] accel_x_in,
	input wire [DW-1:0] accel_y_in,
	input wire [DW-1:0] accel_z_in,
	// Status and timing outputs
	output reg [3:0] orient_state_out,
	output reg orient_change_out,
	output reg event_active_out,
	output reg [9:0] debounce_step_out,
	output reg [17:0] debounce_latency_out
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function [9:0] step_lookup;
		input [2:0] odr;
		input [1:0] osm;
		begin
			case (odr)
				`OMED_ODR_800: step_lookup = `OMED_STEP_1P25MS;
				`OMED_ODR_400: step_lookup = `OMED_STEP_2P5MS;
				`OMED_ODR_200: step_lookup = `OMED_STEP_5MS;
				`OMED_ODR_100: step_lookup = `OMED_STEP_10MS;
				`OMED_ODR_50: step_lookup = `OMED_STEP_20MS;
				default:
				begin
					case (osm)
						`OMED_OS_NORMAL: step_lookup = `OMED_STEP_20MS;
						`OMED_OS_LNLP: step_lookup = `OMED_STEP_80MS;
						`OMED_OS_LP: step_lookup = (odr == 3'h5) ? `OMED_STEP_80MS
							: `OMED_STEP_160MS;
						default: step_lookup = `OMED_STEP_2P5MS;
					endcase
				end
			endcase
			// Fine resolution never steps slower than 2.5 ms
			if (osm == `OMED_OS_FINE && odr != `OMED_ODR_800)
				step_lookup = `OMED_STEP_2P5MS;
		end
	endfunction

	// Magnitude above threshold; the most negative code saturates high
	function above_ths;
		input [DW-1:0] a;
		input [6:0] ths;
		reg [DW-1:0] mag;
		begin
			mag = a[DW-1] ? (~a + {{(DW-1){1'b0}}, 1'b1}) : a;
			above_ths = (a[DW-1] && mag[DW-1]) || (mag > {{(DW-7){1'b0}}, ths});
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers

	reg [7:0] or_cfg_q;
	reg [7:0] or_cnt_q;
	reg [7:0] mt_cfg_q;
	reg [7:0] mt_ths_q;
	reg [7:0] mt_cnt_q;
	reg [7:0] or_dbc_q;
	reg [7:0] mt_dbc_q;
	reg [5:0] mt_flags_q;
	reg first_q;

	wire or_en = or_cfg_q[`OMED_CFG_EN_BIT];
	wire or_dbm = or_cfg_q[`OMED_CFG_DBM_BIT];
	wire event_latch_enable = mt_cfg_q[`OMED_MT_ELE_BIT];
	wire or_combine_select = mt_cfg_q[`OMED_MT_OAE_BIT];
	wire [2:0] axis_en = {mt_cfg_q[`OMED_MT_ZEN_BIT], mt_cfg_q[`OMED_MT_YEN_BIT],
		mt_cfg_q[`OMED_MT_XEN_BIT]};
	wire mt_dbm = mt_ths_q[`OMED_THS_DBM_BIT];
	wire stat_rd = reg_rd_in && (reg_addr_in == `OMED_ADDR_OR_STAT);
	wire src_rd = reg_rd_in && (reg_addr_in == `OMED_ADDR_MT_SRC);

	always @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			or_cfg_q <= `OMED_OR_CFG_RST;
			or_cnt_q <= `OMED_OR_CNT_RST;
			mt_cfg_q <= `OMED_MT_CFG_RST;
			mt_ths_q <= `OMED_MT_THS_RST;
			mt_cnt_q <= `OMED_MT_CNT_RST;
		end
		else if (reg_wr_in)
		begin
			case (reg_addr_in)
				`OMED_ADDR_OR_CFG: or_cfg_q <= {reg_wdata_in[7:6], 6'h00};
				`OMED_ADDR_OR_CNT: or_cnt_q <= reg_wdata_in;
				`OMED_ADDR_MT_CFG: mt_cfg_q <= {reg_wdata_in[7:3], 3'h0};
				`OMED_ADDR_MT_THS: mt_ths_q <= reg_wdata_in;
				`OMED_ADDR_MT_CNT: mt_cnt_q <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Time step and latency, recomputed every cycle from the rate inputs

	always @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			debounce_step_out <= 10'h000;
			debounce_latency_out <= 18'h00000;
		end
		else
		begin
			debounce_step_out <= step_lookup(odr_sel_in, os_mode_in);
			debounce_latency_out <= or_cnt_q * step_lookup(odr_sel_in, os_mode_in);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Orientation debounce

	// A pending first detection after activation counts as a change
	wire or_pend = (orient_cand_in != orient_state_out) || first_q;

	always @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			or_dbc_q <= 8'h00;
			orient_state_out <= 4'h0;
			orient_change_out <= 1'b0;
			first_q <= 1'b0;
		end
		else
		begin
			if (standby_to_active_in)
				first_q <= 1'b1;
			// Read clears the change flag; a commit in the same cycle wins
			if (stat_rd)
				orient_change_out <= 1'b0;
			if (!or_en || wake_sleep_change_in)
				or_dbc_q <= 8'h00;
			else if (sample_tick_in)
			begin
				if (or_pend)
				begin
					if (or_dbc_q >= or_cnt_q)
					begin
						or_dbc_q <= 8'h00;
						if (orient_cand_in != orient_state_out || first_q)
							orient_change_out <= 1'b1;
						orient_state_out <= orient_cand_in;
						first_q <= 1'b0;
					end
					else
						or_dbc_q <= or_dbc_q + 8'h01;
				end
				else if (or_dbm)
					or_dbc_q <= 8'h00;
				else if (or_dbc_q != 8'h00)
					or_dbc_q <= or_dbc_q - 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Freefall / motion detection

	wire [2:0] hi = {above_ths(accel_z_in, mt_ths_q[6:0]), above_ths(accel_y_in, mt_ths_q[6:0]),
		above_ths(accel_x_in, mt_ths_q[6:0])};
	wire [2:0] sgn = {accel_z_in[DW-1], accel_y_in[DW-1], accel_x_in[DW-1]};
	wire any_en = |axis_en;
	// AND of low-g over enabled axes, or OR of high-g over enabled axes
	wire cond = any_en && (or_combine_select ? |(hi & axis_en) : &(~hi | ~axis_en));
	wire [5:0] raw_flags = {hi[2] & axis_en[2], sgn[2] & hi[2] & axis_en[2],
		hi[1] & axis_en[1], sgn[1] & hi[1] & axis_en[1],
		hi[0] & axis_en[0], sgn[0] & hi[0] & axis_en[0]};

	reg [7:0] dbc_base;
	reg ea_base;
	reg [5:0] flg_base;
	reg [7:0] dbc_inc;

	always @*
	begin
		// Latched read clears first so that a same-cycle sample still counts
		dbc_base = mt_dbc_q;
		ea_base = event_active_out;
		flg_base = mt_flags_q;
		if (src_rd && event_latch_enable)
		begin
			dbc_base = 8'h00;
			ea_base = 1'b0;
			flg_base = 6'h00;
		end
		dbc_inc = (dbc_base == 8'hff) ? dbc_base : dbc_base + 8'h01;
	end

	always @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			mt_dbc_q <= 8'h00;
			event_active_out <= 1'b0;
			mt_flags_q <= 6'h00;
		end
		else if (!any_en)
		begin
			mt_dbc_q <= 8'h00;
			event_active_out <= 1'b0;
			mt_flags_q <= 6'h00;
		end
		else if (!sample_tick_in)
		begin
			mt_dbc_q <= dbc_base;
			event_active_out <= ea_base;
			mt_flags_q <= flg_base;
		end
		else
		begin
			if (!(event_latch_enable && ea_base))
				mt_flags_q <= raw_flags;
			else
				mt_flags_q <= flg_base;
			if (event_latch_enable && ea_base)
			begin
				mt_dbc_q <= dbc_base;
				event_active_out <= 1'b1;
			end
			else if (cond)
			begin
				mt_dbc_q <= (dbc_base >= mt_cnt_q) ? dbc_base : dbc_inc;
				if (dbc_base >= mt_cnt_q || dbc_inc >= mt_cnt_q)
					event_active_out <= 1'b1;
				else
					event_active_out <= ea_base;
			end
			else if (mt_dbm)
			begin
				mt_dbc_q <= 8'h00;
				event_active_out <= 1'b0;
			end
			else
			begin
				// Flag holds until the counter has run back down
				mt_dbc_q <= (dbc_base == 8'h00) ? 8'h00 : dbc_base - 8'h01;
				event_active_out <= event_latch_enable ? 1'b0 : (ea_base && dbc_base > 8'h01);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data

	always @*
	begin
		case (reg_addr_in)
			`OMED_ADDR_OR_STAT: reg_rdata_out = {orient_change_out, orient_state_out[3], 3'h0,
				orient_state_out[2:0]};
			`OMED_ADDR_OR_CFG: reg_rdata_out = or_cfg_q;
			`OMED_ADDR_OR_CNT: reg_rdata_out = or_cnt_q;
			`OMED_ADDR_BF_ZL: reg_rdata_out = {`OMED_BACK_FRONT_TRIP_CODE_CODE, 3'h0, `OMED_TILT_LOCKOUT_CODE_CODE};
			`OMED_ADDR_OR_THS: reg_rdata_out = {`OMED_TRIP_CODE, `OMED_HYS_CODE};
			`OMED_ADDR_MT_CFG: reg_rdata_out = mt_cfg_q;
			`OMED_ADDR_MT_SRC: reg_rdata_out = {event_active_out, 1'b0, mt_flags_q};
			`OMED_ADDR_MT_THS: reg_rdata_out = mt_ths_q;
			`OMED_ADDR_MT_CNT: reg_rdata_out = mt_cnt_q;
			default: reg_rdata_out = 8'h00;
		endcase
	end

endmodule

// ### omed_consts.vh
// Register map, field positions, reset values and fixed codes of the event detector
`ifndef OMED_CONSTS_VH
`define OMED_CONSTS_VH
`define OMED_ADDR_OR_STAT 8'h10
`define OMED_ADDR_OR_CFG 8'h11
`define OMED_ADDR_OR_CNT 8'h12
`define OMED_ADDR_BF_ZL 8'h13
`define OMED_ADDR_OR_THS 8'h14
`define OMED_ADDR_MT_CFG 8'h15
`define OMED_ADDR_MT_SRC 8'h16
`define OMED_ADDR_MT_THS 8'h17
`define OMED_ADDR_MT_CNT 8'h18
`define OMED_CFG_DBM_BIT 7
`define OMED_CFG_EN_BIT 6
`define OMED_MT_ELE_BIT 7
`define OMED_MT_OAE_BIT 6
`define OMED_MT_ZEN_BIT 5
`define OMED_MT_YEN_BIT 4
`define OMED_MT_XEN_BIT 3
`define OMED_THS_DBM_BIT 7
`define OMED_OR_CFG_RST 8'h80
`define OMED_OR_CNT_RST 8'h00
`define OMED_MT_CFG_RST 8'h00
`define OMED_MT_THS_RST 8'h00
`define OMED_MT_CNT_RST 8'h00
`define OMED_BACK_FRONT_TRIP_CODE_CODE 2'h1
`define OMED_TILT_LOCKOUT_CODE_CODE 3'h4
`define OMED_TRIP_CODE 5'h10
`define OMED_HYS_CODE 3'h4
`define OMED_ODR_800 3'h0
`define OMED_ODR_400 3'h1
`define OMED_ODR_200 3'h2
`define OMED_ODR_100 3'h3
`define OMED_ODR_50 3'h4
`define OMED_OS_NORMAL 2'h0
`define OMED_OS_LNLP 2'h1
`define OMED_OS_FINE 2'h2
`define OMED_OS_LP 2'h3
// Time steps in quarter milliseconds
`define OMED_STEP_1P25MS 10'h005
`define OMED_STEP_2P5MS 10'h00a
`define OMED_STEP_5MS 10'h014
`define OMED_STEP_10MS 10'h028
`define OMED_STEP_20MS 10'h050
`define OMED_STEP_80MS 10'h140
`define OMED_STEP_160MS 10'h280
`endif

// ### omed_host.sv
// Host model that drives the register port
`timescale 1ns/10ps
module omed_host (
	input wire clk_sys_in,
	input wire [7:0] rdata_in,
	output reg [7:0] addr_out = 8'h00,
	output reg wr_out = 1'b0,
	output reg rd_out = 1'b0,
	output reg [7:0] wdata_out = 8'h00
);
task wr(input [7:0] a, input [7:0] d);
begin
	@(negedge clk_sys_in);
	{addr_out, wdata_out, wr_out} = {a, d, 1'b1};
	@(negedge clk_sys_in);
	wr_out = 1'b0;
end
endtask
// Read data is taken at the strobe edge, before any clear lands
task rd(input [7:0] a, output [7:0] d);
begin
	@(negedge clk_sys_in);
	{addr_out, rd_out} = {a, 1'b1};
	@(posedge clk_sys_in);
	d = rdata_in;
	@(negedge clk_sys_in);
	rd_out = 1'b0;
end
endtask
endmodule

// ### omed_detector_properties.sv
// Port checker for the event detector
`timescale 1ns/10ps
module omed_detector_chk #(parameter DW = 8) (
	input wire clk_sys_in, rst_b_in, reg_wr_in, reg_rd_in, sample_tick_in,
	input wire wake_sleep_change_in, standby_to_active_in, orient_change_out,
	input wire event_active_out,
	input wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
	input wire [2:0] odr_sel_in,
	input wire [1:0] os_mode_in,
	input wire [3:0] orient_cand_in, orient_state_out,
	input wire [DW-1:0] accel_x_in, accel_y_in, accel_z_in,
	input wire [9:0] debounce_step_out,
	input wire [17:0] debounce_latency_out
);
reg ele_q;
reg en_q;
reg [7:0] cnt_q;
wire src_rd = reg_rd_in && reg_addr_in == 8'h16 && !reg_wr_in;
// Shadow of host writes, so the checks know the modes
always @(posedge clk_sys_in or negedge rst_b_in)
	if (!rst_b_in)
		{ele_q, en_q, cnt_q} <= 10'h000;
	else if (reg_wr_in && reg_addr_in == 8'h15)
		ele_q <= reg_wdata_in[7];
	else if (reg_wr_in && reg_addr_in == 8'h11)
		en_q <= reg_wdata_in[6];
	else if (reg_wr_in && reg_addr_in == 8'h12)
		cnt_q <= reg_wdata_in;
////////////////////////////////////////////////////////////
default clocking cb @(posedge clk_sys_in);
endclocking
default disable iff (!rst_b_in);
sequence quiet4;
	(!reg_wr_in && $stable(odr_sel_in) && $stable(os_mode_in))[*4];
endsequence
sequence chg_rd;
	!$past(sample_tick_in) ##0 reg_rd_in && reg_addr_in == 8'h10 && !sample_tick_in;
endsequence
a_bf_code: assert property (reg_addr_in == 8'h13 |-> reg_rdata_out == 8'h44)
	else $error("bad back front code");
a_trip_code: assert property (reg_addr_in == 8'h14 |-> reg_rdata_out == 8'h84)
	else $error("bad trip code");
a_ea_on_tick: assert property ($rose(event_active_out) |-> $past(sample_tick_in))
	else $error("event without sample");
a_ea_quiet: assert property (
	!sample_tick_in && !src_rd && !reg_wr_in |=> $stable(event_active_out))
	else $error("event moved between samples");
a_latch_hold: assert property (
	ele_q && event_active_out && !src_rd && !reg_wr_in |=> event_active_out)
	else $error("latched event dropped");
a_latch_clear: assert property (
	ele_q && src_rd && !sample_tick_in |=> !event_active_out)
	else $error("latched event not cleared");
a_plain_read: assert property (
	!ele_q && src_rd && !sample_tick_in |=> $stable(event_active_out))
	else $error("read changed live event");
a_chg_clear: assert property (chg_rd |=> !orient_change_out)
	else $error("change flag not cleared");
a_latency: assert property (
	quiet4 |-> debounce_latency_out == cnt_q * debounce_step_out)
	else $error("bad debounce latency");
a_off_hold: assert property ((!en_q)[*3] |-> $stable(orient_state_out))
	else $error("orientation moved while off");
endmodule
bind omed_detector omed_detector_chk #(.DW(DW)) u_omed_detector_chk (.*);

// ### omed_detector_tb_top.sv
// Self-checking bench for the event detector
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
	$display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module omed_detector_tb_top;
reg clk = 1'b0;
reg rst_b, tick, sta, wsc;
reg [2:0] odr;
reg [1:0] osm;
reg [3:0] cand;
reg [7:0] ax, ay, az, v, c;
wire [7:0] addr, wdata, rdata;
wire wr, rd, chg, ea;
wire [3:0] ost;
wire [9:0] step;
wire [17:0] lat;
integer bad_count, checks_done, seed, i;
localparam [79:0] RST_EXP = 80'h00800044840000000000;
omed_host u_omed_host (.clk_sys_in(clk), .rdata_in(rdata), .addr_out(addr),
	.wr_out(wr), .rd_out(rd), .wdata_out(wdata));
omed_detector u_omed_detector (.clk_sys_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr),
	.reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
	.sample_tick_in(tick), .wake_sleep_change_in(wsc), .standby_to_active_in(sta),
	.odr_sel_in(odr), .os_mode_in(osm), .orient_cand_in(cand), .accel_x_in(ax),
	.accel_y_in(ay), .accel_z_in(az), .orient_state_out(ost), .orient_change_out(chg),
	.event_active_out(ea), .debounce_step_out(step), .debounce_latency_out(lat));
////////////////////////////////////////////////////////////
// Step in quarter milliseconds
function [9:0] exp_step(input [2:0] o, input [1:0] m);
	exp_step = (o < 3'h2) ? (o[0] ? 10'h00a : 10'h005) : (m == 2'h2) ? 10'h00a :
		(o < 3'h5) ? (10'h014 << (o - 3'h2)) : (m == 2'h0) ? 10'h050 :
		(m == 2'h3 && o > 3'h5) ? 10'h280 : 10'h140;
endfunction
// Unenabled axes get random data; it must never matter
task tk(input integer n);
	repeat (n)
	begin
		@(negedge clk);
		tick = 1'b1;
		{ay, az} = $random(seed);
		@(negedge clk);
		tick = 1'b0;
	end
endtask
task summarize;
begin
	$display("checks %0d mismatches %0d", checks_done, bad_count);
	if (bad_count == 0 && checks_done > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
end
endtask
initial forever #20 clk = ~clk;
initial
begin
	#200000;
	bad_count++;
	summarize;
end
initial
begin
	bad_count = 0;
	checks_done = 0;
	seed = 32'h3fdf;
	{rst_b, tick, sta, wsc, odr, osm, cand, ax, ay, az} = 38'h0;
	repeat (10) @(negedge clk);
	rst_b = 1'b1;
	for (i = 0; i < 10; i++)
	begin
		u_omed_host.rd(i < 9 ? 8'h10 + i : 8'h20, v);
		`CHK(v, RST_EXP[79 - 8 * i -: 8])
	end
	c = $random(seed);
	u_omed_host.wr(8'h12, c);
	u_omed_host.wr(8'h13, ~c);
	u_omed_host.rd(8'h12, v);
	`CHK(v, c)
	u_omed_host.rd(8'h13, v);
	`CHK(v, 8'h44)
	for (i = 0; i < 32; i++)
	begin
		{odr, osm} = i[4:0];
		repeat (4) @(negedge clk);
		`CHK(step, exp_step(odr, osm))
		`CHK(lat, c * exp_step(odr, osm))
	end
	$display("test registers and steps done");
	u_omed_host.wr(8'h18, 8'h02);
	u_omed_host.wr(8'h17, 8'h90);
	for (i = 0; i < 4; i++)
	begin
		u_omed_host.wr(8'h15, {i[1:0], 6'h08});
		ax = i[0] ? 8'h40 : 8'h05;
		tk(1);
		`CHK(ea, 1'b0)
		tk(1);
		`CHK(ea, 1'b1)
		u_omed_host.rd(8'h16, v);
		`CHK(v, i[0] ? 8'h82 : 8'h80)
		`CHK(ea, ~i[1])
		ax = i[0] ? 8'h05 : 8'h40;
		tk(1);
		`CHK(ea, 1'b0)
	end
	u_omed_host.wr(8'h17, 8'h10);
	u_omed_host.wr(8'h15, 8'h48);
	ax = 8'h40;
	tk(2);
	ax = 8'h00;
	tk(1);
	`CHK(ea, 1'b1)
	tk(1);
	`CHK(ea, 1'b0)
	u_omed_host.wr(8'h15, 8'h40);
	ax = 8'h40;
	tk(3);
	`CHK(ea, 1'b0)
	$display("test motion modes done");
	cand = 4'h6;
	tk(3);
	`CHK(ost, 4'h0)
	u_omed_host.wr(8'h12, 8'h01);
	u_omed_host.wr(8'h11, 8'hc0);
	@(negedge clk) sta = 1'b1;
	@(negedge clk) sta = 1'b0;
	tk(4);
	`CHK(ost, cand)
	u_omed_host.rd(8'h10, v);
	`CHK(v, {1'b1, cand[3], 3'h0, cand[2:0]})
	`CHK(chg, 1'b0)
	// A wake/sleep change in mid-count must restart the count
	cand = 4'h9;
	tk(1);
	@(negedge clk) wsc = 1'b1;
	@(negedge clk) wsc = 1'b0;
	tk(1);
	`CHK(ost, 4'h6)
	tk(1);
	`CHK(ost, 4'h9)
	// Decrement mode keeps partial progress across a brief loss
	u_omed_host.wr(8'h12, 8'h02);
	u_omed_host.wr(8'h11, 8'h40);
	cand = 4'h3;
	tk(2);
	cand = 4'h9;
	tk(1);
	cand = 4'h3;
	tk(2);
	`CHK(ost, 4'h3)
	$display("test orientation done");
	summarize;
end
endmodule
